// ### common/dbs_pkg.sv
// Purpose: Shared constants and carrier types for the debug support block
// Assumes: AXI4-Lite slave, 32-bit data, one register per aligned word
// Notes: Register offsets are word indices; byte address is four times the index
`default_nettype none
package dbs_pkg;
  // Bus geometry
  localparam int AXI_ADDR_W = 20;
  localparam int AXI_DATA_W = 32;
  localparam int REG_IDX_W = AXI_ADDR_W - 2;

  // Register word indices and their byte addresses
  localparam logic [REG_IDX_W-1:0] ABORT_GEN_IDX = 18'h0_fde8;
  localparam logic [REG_IDX_W-1:0] IRQ_SRC_IDX = 18'h0_fdea;
  localparam logic [REG_IDX_W-1:0] DBG_CFG_IDX = 18'h0_ff16;
  localparam logic [AXI_ADDR_W-1:0] ABORT_GEN_ADDR = {ABORT_GEN_IDX, 2'b00};
  localparam logic [AXI_ADDR_W-1:0] IRQ_SRC_ADDR = {IRQ_SRC_IDX, 2'b00};
  localparam logic [AXI_ADDR_W-1:0] DBG_CFG_ADDR = {DBG_CFG_IDX, 2'b00};

  // Field positions
  localparam int ABORT_P0_BIT = 0;
  localparam int SRC_RX_BIT = 0;
  localparam int SRC_ABORT_BIT = 1;
  localparam int CFG_ON_BIT = 0;
  localparam int CFG_FREEZE_BIT = 1;
  localparam int CFG_BREAK_LINE_ENABLE_BIT = 2;

  // Implemented bits and reset values
  localparam logic [15:0] IRQ_SRC_MASK = 16'h0003;
  localparam logic [15:0] IRQ_SRC_RESET = 16'h0000;
  localparam logic [7:0] DBG_CFG_MASK = 8'h07;
  localparam logic [7:0] DBG_CFG_RESET = 8'h00;

  // Reset indication pulse length in core clock cycles
  localparam int RESET_PULSE_OUTPUT_MIN_CYC = 3;
  localparam int RESET_PULSE_OUTPUT_CNT_W = 4;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {SEL_NONE, SEL_ABORT, SEL_SRC, SEL_CFG} dbs_reg_sel_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_BRESP, BUS_RRESP} dbs_bus_st_t;

  // Master to slave
  typedef struct packed {
    logic awvalid;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [AXI_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_ADDR_W-1:0] araddr;
    logic rready;
  } dbs_axil_req_t;

  // Slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } dbs_axil_rsp_t;
endpackage
`default_nettype wire

// ### rtl/dbs_debug_support.sv
// Purpose: Abort generation, emulator interrupt sources, break/reset shared pin and output-disable strap
// Assumes: All inputs synchronous to core_clk_in; event inputs are one-cycle pulses
// Notes: Break line is active low on the shared pin; the pin is pulled high externally
`default_nettype none
// Operation
// - Writing one to abort_generate bit 0 raises an abort towards processor zero.
// - Writing zero to abort_generate bit 0 does nothing and raises no interrupt.
// - Source flags reset to zero; write one clears a bit, zero leaves it.
// - Flag bit 0 sets on a receive data-link event and stays until cleared.
// - Flag bit 1 sets on debugger abort command or abort_generate write.
// - Flag bits 7 to 2 are reserved, read zero, do nothing.
// - Debugger reset instruction always recovers by resetting the whole device.
// - Emulator interrupt is non-maskable and fires on a rising edge.
// - Emulator interrupt is asserted only for receive and abort events.
// - Emulator interrupt is delivered only while debug enable is one.
// - Break line counts only in development environment with both enables set.
// - Break during fetch stops on that instruction only if it executes.
// - Shared pin is driven low as a pulse whenever the core is in reset, no bus select strobe is active and the strap has not set high impedance.
// - Shared pin is an input while any bus select strobe is active.
// - With no bus activity, reset drives the pin low for at least three cycles.
// - Output-disable strap is sampled once after power-up in normal or onboard use.
// - Strap sampled high places the outputs in high impedance.
module dbs_debug_support #(
  parameter int RESET_PULSE_OUTPUT_MIN_CYC = dbs_pkg::RESET_PULSE_OUTPUT_MIN_CYC
) (
  input wire logic core_clk_in, // Core clock, 100 MHz
  input wire logic rstn_in, // Asynchronous reset, active low
  input wire dbs_pkg::dbs_axil_req_t axil_req_in, // AXI4-Lite master signals
  output dbs_pkg::dbs_axil_rsp_t axil_rsp_out, // AXI4-Lite slave signals
  input wire logic dev_env_in, // Development environment
  input wire logic onboard_env_in, // Onboard environment
  input wire logic rx_event_in, // Receive data-link event pulse
  input wire logic dbg_abort_cmd_in, // Debugger abort command pulse
  input wire logic dbg_reset_cmd_in, // Debugger reset instruction pulse
  input wire logic core_in_reset_in, // Core held in reset, any source
  input wire logic io_expansion_select_in, // I/O expansion select strobe
  input wire logic zone0_select_in, // Zone 0 select strobe
  input wire logic zone1_select_in, // Zone 1 select strobe
  input wire logic instr_fetch_in, // Instruction fetch strobe
  input wire logic instr_exec_in, // Fetched instruction executes
  input wire logic instr_flush_in, // Fetched instruction discarded
  input wire logic output_disable_strap_in, // Output-disable strap level
  input wire logic brk_pin_in, // Shared pin level, break active low
  output logic brk_pin_out, // Shared pin drive value
  output logic brk_pin_oe_out, // Shared pin output enable
  output logic emulator_interrupt_out, // Emulator interrupt pulse to core
  output logic abort_p0_out, // Abort pulse towards processor 0
  output logic core_break_out, // Break request pulse to core
  output logic device_reset_req_out, // Whole-device reset request pulse
  output logic freeze_out, // Freeze control level
  output logic outputs_hiz_out // All outputs to high impedance
);

  // Elaboration check on the pulse length
  if (RESET_PULSE_OUTPUT_MIN_CYC < 1 || RESET_PULSE_OUTPUT_MIN_CYC >= (1 << dbs_pkg::RESET_PULSE_OUTPUT_CNT_W)) begin : g_chk
    $error("RESET_PULSE_OUTPUT_MIN_CYC out of range");
  end

  localparam logic [dbs_pkg::RESET_PULSE_OUTPUT_CNT_W-1:0] RESET_PULSE_OUTPUT_INIT = dbs_pkg::RESET_PULSE_OUTPUT_CNT_W'(RESET_PULSE_OUTPUT_MIN_CYC);

  typedef struct packed {
    dbs_pkg::dbs_bus_st_t bus;
    logic aw_got;
    logic w_got;
    logic [dbs_pkg::AXI_ADDR_W-1:0] waddr;
    logic [dbs_pkg::AXI_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [dbs_pkg::AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [15:0] flags;
    logic [7:0] cfg;
    logic ise_prev;
    logic ise_pulse;
    logic abort_pulse;
    logic [dbs_pkg::RESET_PULSE_OUTPUT_CNT_W-1:0] reset_pulse_output_cnt;
    logic brk_pend;
    logic brk_fire;
    logic rst_req;
    logic strap_done;
    logic hiz;
  } dbs_state_t;

  dbs_state_t st_r;
  dbs_state_t st_nxt;

  logic awready;
  logic wready;
  logic arready;
  logic sel_any;
  logic on_gate;
  logic ise_level;
  logic brk_enabled;
  logic reset_pulse_output_active;
  logic abort_wr_hit;
  logic [15:0] src_clr;
  logic [15:0] src_set;

  // Register decode shared by read and write paths
  function automatic dbs_pkg::dbs_reg_sel_t reg_sel(input logic [dbs_pkg::AXI_ADDR_W-1:0] addr);
    if (addr[dbs_pkg::AXI_ADDR_W-1:2] == dbs_pkg::ABORT_GEN_IDX) begin
      return dbs_pkg::SEL_ABORT;
    end else if (addr[dbs_pkg::AXI_ADDR_W-1:2] == dbs_pkg::IRQ_SRC_IDX) begin
      return dbs_pkg::SEL_SRC;
    end else if (addr[dbs_pkg::AXI_ADDR_W-1:2] == dbs_pkg::DBG_CFG_IDX) begin
      return dbs_pkg::SEL_CFG;
    end else begin
      return dbs_pkg::SEL_NONE;
    end
  endfunction

  // Handshake readies; a read waits while a write is being collected
  assign awready = (st_r.bus == dbs_pkg::BUS_IDLE) && !st_r.aw_got;
  assign wready = (st_r.bus == dbs_pkg::BUS_IDLE) && !st_r.w_got;
  assign arready = (st_r.bus == dbs_pkg::BUS_IDLE) && !st_r.aw_got && !st_r.w_got &&
                   !axil_req_in.awvalid && !axil_req_in.wvalid;

  // Gating terms
  assign sel_any = io_expansion_select_in | zone0_select_in | zone1_select_in;
  assign on_gate = st_r.cfg[dbs_pkg::CFG_ON_BIT] & (dev_env_in | onboard_env_in);
  assign ise_level = on_gate & (st_r.flags[dbs_pkg::SRC_RX_BIT] | st_r.flags[dbs_pkg::SRC_ABORT_BIT]);
  assign brk_enabled = dev_env_in & st_r.cfg[dbs_pkg::CFG_ON_BIT] & st_r.cfg[dbs_pkg::CFG_BREAK_LINE_ENABLE_BIT] &
                       sel_any & !brk_pin_in;
  assign reset_pulse_output_active = core_in_reset_in | (st_r.reset_pulse_output_cnt != '0);

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    abort_wr_hit = 1'b0;
    src_clr = '0;
    src_set = '0;
    st_nxt.abort_pulse = 1'b0;
    // Address and data may arrive in either order
    if (axil_req_in.awvalid && awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.waddr = axil_req_in.awaddr;
    end
    if (axil_req_in.wvalid && wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = axil_req_in.wdata;
      st_nxt.wstrb = axil_req_in.wstrb;
    end
    case (st_r.bus)
      dbs_pkg::BUS_IDLE: begin
        if (st_r.aw_got && st_r.w_got) begin
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got = 1'b0;
          st_nxt.bus = dbs_pkg::BUS_BRESP;
          st_nxt.bresp = dbs_pkg::RESP_OKAY;
          case (reg_sel(st_r.waddr))
            dbs_pkg::SEL_ABORT: begin
              abort_wr_hit = st_r.wstrb[0] & st_r.wdata[dbs_pkg::ABORT_P0_BIT];
            end
            dbs_pkg::SEL_SRC: begin
              if (st_r.wstrb[0]) begin
                src_clr = {8'h00, st_r.wdata[7:0]} & dbs_pkg::IRQ_SRC_MASK;
              end
            end
            dbs_pkg::SEL_CFG: begin
              if (st_r.wstrb[0]) begin
                st_nxt.cfg = st_r.wdata[7:0] & dbs_pkg::DBG_CFG_MASK;
              end
            end
            default: begin
              st_nxt.bresp = dbs_pkg::RESP_SLVERR;
            end
          endcase
        end else if (axil_req_in.arvalid && arready) begin
          st_nxt.bus = dbs_pkg::BUS_RRESP;
          st_nxt.rresp = dbs_pkg::RESP_OKAY;
          st_nxt.rdata = '0;
          case (reg_sel(axil_req_in.araddr))
            dbs_pkg::SEL_ABORT: begin
              st_nxt.rdata = '0;
            end
            dbs_pkg::SEL_SRC: begin
              st_nxt.rdata = {16'h0000, st_r.flags & dbs_pkg::IRQ_SRC_MASK};
            end
            dbs_pkg::SEL_CFG: begin
              st_nxt.rdata = {24'h00_0000, st_r.cfg};
            end
            default: begin
              st_nxt.rresp = dbs_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      dbs_pkg::BUS_BRESP: begin
        if (axil_req_in.bready) begin
          st_nxt.bus = dbs_pkg::BUS_IDLE;
        end
      end
      dbs_pkg::BUS_RRESP: begin
        if (axil_req_in.rready) begin
          st_nxt.bus = dbs_pkg::BUS_IDLE;
        end
      end
      default: begin
        st_nxt.bus = dbs_pkg::BUS_IDLE;
      end
    endcase
    // Interrupt source flags, set beats clear
    src_set[dbs_pkg::SRC_RX_BIT] = rx_event_in;
    src_set[dbs_pkg::SRC_ABORT_BIT] = abort_wr_hit | dbg_abort_cmd_in;
    st_nxt.flags = ((st_r.flags & ~src_clr) | src_set) & dbs_pkg::IRQ_SRC_MASK;
    st_nxt.abort_pulse = abort_wr_hit;
    // Rising-edge emulator interrupt pulse
    st_nxt.ise_prev = ise_level;
    st_nxt.ise_pulse = ise_level & !st_r.ise_prev;
    // Reset indication stretch
    if (core_in_reset_in) begin
      st_nxt.reset_pulse_output_cnt = RESET_PULSE_OUTPUT_INIT;
    end else if (st_r.reset_pulse_output_cnt != '0) begin
      st_nxt.reset_pulse_output_cnt = st_r.reset_pulse_output_cnt - 1'b1;
    end
    // Break request held from fetch until execute or flush
    st_nxt.brk_fire = st_r.brk_pend & instr_exec_in;
    if (instr_exec_in || instr_flush_in) begin
      st_nxt.brk_pend = 1'b0;
    end
    if (instr_fetch_in) begin
      st_nxt.brk_pend = brk_enabled;
    end
    // Debugger reset instruction becomes a device reset request
    st_nxt.rst_req = dbg_reset_cmd_in;
    // One-time strap capture after reset release
    if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.hiz = output_disable_strap_in & !dev_env_in;
    end
  end

  // State register
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= '0;
      st_r.bus <= dbs_pkg::BUS_IDLE;
      st_r.flags <= dbs_pkg::IRQ_SRC_RESET;
      st_r.cfg <= dbs_pkg::DBG_CFG_RESET;
      st_r.reset_pulse_output_cnt <= RESET_PULSE_OUTPUT_INIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Bus answers
  always_comb begin
    axil_rsp_out = '0;
    axil_rsp_out.awready = awready;
    axil_rsp_out.wready = wready;
    axil_rsp_out.arready = arready;
    axil_rsp_out.bvalid = (st_r.bus == dbs_pkg::BUS_BRESP);
    axil_rsp_out.bresp = st_r.bresp;
    axil_rsp_out.rvalid = (st_r.bus == dbs_pkg::BUS_RRESP);
    axil_rsp_out.rdata = st_r.rdata;
    axil_rsp_out.rresp = st_r.rresp;
  end

  // Pin and core-side outputs
  assign brk_pin_out = 1'b0;
  assign brk_pin_oe_out = reset_pulse_output_active & !sel_any & !st_r.hiz;
  assign emulator_interrupt_out = st_r.ise_pulse;
  assign abort_p0_out = st_r.abort_pulse;
  assign core_break_out = st_r.brk_fire;
  assign device_reset_req_out = st_r.rst_req;
  assign freeze_out = st_r.cfg[dbs_pkg::CFG_FREEZE_BIT];
  assign outputs_hiz_out = st_r.hiz;

  // Checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_abort_write;
    abort_wr_hit;
  endsequence

  sequence s_abort_seen;
    st_r.flags[dbs_pkg::SRC_ABORT_BIT] && abort_p0_out;
  endsequence

  property p_abort_set;
    s_abort_write |=> s_abort_seen;
  endproperty
  a_abort_set: assert property (p_abort_set) else $error("abort write did not set flag");

  property p_zero_no_effect;
    (!abort_wr_hit && !dbg_abort_cmd_in && !src_clr[dbs_pkg::SRC_ABORT_BIT]) |=>
      (st_r.flags[dbs_pkg::SRC_ABORT_BIT] == $past(st_r.flags[dbs_pkg::SRC_ABORT_BIT])) && !abort_p0_out;
  endproperty
  a_zero_no_effect: assert property (p_zero_no_effect) else $error("abort flag changed without cause");

  property p_clear;
    (src_clr[dbs_pkg::SRC_RX_BIT] && !rx_event_in) |=> !st_r.flags[dbs_pkg::SRC_RX_BIT];
  endproperty
  a_clear: assert property (p_clear) else $error("write one did not clear flag");

  property p_rx_set;
    rx_event_in |=> st_r.flags[dbs_pkg::SRC_RX_BIT];
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("receive event did not set flag");

  property p_reserved_zero;
    st_r.flags[15:2] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved flag bit set");

  property p_set_wins;
    (rx_event_in && src_clr[dbs_pkg::SRC_RX_BIT]) |=> st_r.flags[dbs_pkg::SRC_RX_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a set event");

  property p_reset_req;
    dbg_reset_cmd_in |=> device_reset_req_out;
  endproperty
  a_reset_req: assert property (p_reset_req) else $error("reset instruction lost");

  property p_irq_edge;
    emulator_interrupt_out |=> !emulator_interrupt_out;
  endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("interrupt not a single pulse");

  property p_irq_source;
    emulator_interrupt_out |-> ($past(st_r.flags) & dbs_pkg::IRQ_SRC_MASK) != '0;
  endproperty
  a_irq_source: assert property (p_irq_source) else $error("interrupt without source");

  property p_irq_gate;
    emulator_interrupt_out |-> $past(on_gate);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt while debug disabled");

  property p_break_gate;
    core_break_out |-> $past(instr_exec_in) && dev_env_in;
  endproperty
  a_break_gate: assert property (p_break_gate) else $error("break without execute");

  property p_break_enable;
    $rose(st_r.brk_pend) |-> $past(dev_env_in && st_r.cfg[dbs_pkg::CFG_ON_BIT] && st_r.cfg[dbs_pkg::CFG_BREAK_LINE_ENABLE_BIT]);
  endproperty
  a_break_enable: assert property (p_break_enable) else $error("break line taken while disabled");

  property p_abort_cmd;
    dbg_abort_cmd_in |=> st_r.flags[dbs_pkg::SRC_ABORT_BIT];
  endproperty
  a_abort_cmd: assert property (p_abort_cmd) else $error("abort command did not set flag");

  property p_reset_pulse_output_low;
    (core_in_reset_in && !sel_any && !outputs_hiz_out) |-> brk_pin_oe_out && !brk_pin_out;
  endproperty
  a_reset_pulse_output_low: assert property (p_reset_pulse_output_low) else $error("pin not low during reset");

  property p_sel_input;
    sel_any |-> !brk_pin_oe_out;
  endproperty
  a_sel_input: assert property (p_sel_input) else $error("pin driven during bus activity");

  property p_reset_pulse_output_len;
    $rose(reset_pulse_output_active) |-> reset_pulse_output_active [*4];
  endproperty
  a_reset_pulse_output_len: assert property (p_reset_pulse_output_len) else $error("reset pulse too short");

  property p_strap_once;
    st_r.strap_done |=> $stable(outputs_hiz_out);
  endproperty
  a_strap_once: assert property (p_strap_once) else $error("strap resampled");

  property p_hiz;
    outputs_hiz_out |-> !brk_pin_oe_out;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pin driven while outputs disabled");

endmodule
`default_nettype wire

// ### sim/dbs_far_model.sv
// Purpose: Far-side model of the debugger host and the breakpoint hardware
// Assumes: Tasks are called just after a rising clock edge
// Notes: The model drives the shared pin only while a bus select strobe is active
`default_nettype none
module dbs_far_model (
  input wire logic core_clk_in, // Core clock
  input wire logic sel_any_in, // Any bus select strobe active
  output logic rx_event_out, // Receive data-link event pulse
  output logic abort_cmd_out, // Debugger abort command pulse
  output logic reset_cmd_out, // Debugger reset instruction pulse
  output logic pin_oe_out, // Model drives the shared pin
  output logic pin_val_out // Level driven on the shared pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic brk_want;
  initial begin
    rx_event_out = 1'b0;
    abort_cmd_out = 1'b0;
    reset_cmd_out = 1'b0;
    brk_want = 1'b0;
  end
  // Break hardware drives the pin only during bus activity, low for a break; the pull-up holds it otherwise
  assign pin_oe_out = sel_any_in;
  assign pin_val_out = !brk_want;
  // One-cycle event pulse: 0 receive, 1 abort, other reset instruction
  task automatic ev(input int k);
    case (k)
      0: rx_event_out <= 1'b1;
      1: abort_cmd_out <= 1'b1;
      default: reset_cmd_out <= 1'b1;
    endcase
    @(posedge core_clk_in);
    rx_event_out <= 1'b0;
    abort_cmd_out <= 1'b0;
    reset_cmd_out <= 1'b0;
  endtask
  task automatic brk(input logic on);
    brk_want <= on;
  endtask
endmodule
`default_nettype wire

// ### sim/tb.sv
// Purpose: Self-checking bench for the debug support block
// Assumes: AXI4-Lite master driven by non-blocking assignment after rising edges
// Notes: Pulse outputs are counted every cycle; reset requests are compared as totals, the rest as deltas
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, dev, onboard_environment, core_rst, sel_io, zone0_select, zone1_select, fetch, exec, flush, strap;
  logic rx_ev, abt_cmd, rst_cmd, m_oe, m_val, pin_oe, pin_out, irq, abt, brk, rreq, frz, hiz;
  wire pin_lvl;
  wire sel_any;
  dbs_pkg::dbs_axil_req_t req;
  dbs_pkg::dbs_axil_rsp_t rsp;
  int n_errors, num_checks, n_irq, n_abt, n_brk, n_rst, cyc_cnt;
  logic [3:0] wstrb_v;
  // Shared pin resolution with external pull-up
  assign sel_any = sel_io | zone0_select | zone1_select;
  assign pin_lvl = pin_oe ? pin_out : (m_oe ? m_val : 1'b1);
  dbs_debug_support u_dbs_debug_support (.core_clk_in(clk), .rstn_in(rstn), .axil_req_in(req),
    .axil_rsp_out(rsp), .dev_env_in(dev), .onboard_env_in(onboard_environment), .rx_event_in(rx_ev),
    .dbg_abort_cmd_in(abt_cmd), .dbg_reset_cmd_in(rst_cmd), .core_in_reset_in(core_rst),
    .io_expansion_select_in(sel_io), .zone0_select_in(zone0_select), .zone1_select_in(zone1_select),
    .instr_fetch_in(fetch), .instr_exec_in(exec), .instr_flush_in(flush),
    .output_disable_strap_in(strap), .brk_pin_in(pin_lvl), .brk_pin_out(pin_out),
    .brk_pin_oe_out(pin_oe), .emulator_interrupt_out(irq), .abort_p0_out(abt),
    .core_break_out(brk), .device_reset_req_out(rreq), .freeze_out(frz), .outputs_hiz_out(hiz));
  dbs_far_model u_dbs_far_model (.core_clk_in(clk), .sel_any_in(sel_any), .rx_event_out(rx_ev),
    .abort_cmd_out(abt_cmd), .reset_cmd_out(rst_cmd), .pin_oe_out(m_oe), .pin_val_out(m_val));
  always #5 clk = ~clk;
  // Pulse counters and hang guard
  always @(posedge clk) begin
    n_irq += (irq === 1'b1);
    n_abt += (abt === 1'b1);
    n_brk += (brk === 1'b1);
    n_rst += (rreq === 1'b1);
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= wstrb_v;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        chk(rsp.bresp, er);
        req.bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd_chk(input logic [19:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        chk(rsp.rresp, er);
        if (er === dbs_pkg::RESP_OKAY) chk(rsp.rdata, e);
        req.rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic instr(input logic ex);
    @(posedge clk);
    fetch <= 1'b1;
    @(posedge clk);
    fetch <= 1'b0;
    exec <= ex;
    flush <= !ex;
    @(posedge clk);
    exec <= 1'b0;
    flush <= 1'b0;
    cyc(3);
  endtask
  task automatic t_reset(input logic s);
    int n;
    n = 0;
    strap <= s;
    rstn <= 1'b0;
    cyc(5);
    chk(pin_oe, 1);
    chk(pin_lvl, 0);
    rstn <= 1'b1;
    repeat (6) begin
      @(posedge clk);
      n += (pin_oe === 1'b1);
    end
    if (s) chk(pin_oe, 0);
    else chk(n >= 3, 1);
    chk(hiz, s);
    rd_chk(dbs_pkg::IRQ_SRC_ADDR, 0, dbs_pkg::RESP_OKAY);
    rd_chk(dbs_pkg::ABORT_GEN_ADDR, 0, dbs_pkg::RESP_OKAY);
    rd_chk(20'h0_0100, 0, dbs_pkg::RESP_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_irq();
    int b;
    b = n_irq;
    wr(dbs_pkg::DBG_CFG_ADDR, 0, dbs_pkg::RESP_OKAY);
    u_dbs_far_model.ev(0);
    cyc(4);
    chk(n_irq - b, 0);
    // Enabled, but in neither debug environment
    onboard_environment <= 1'b0;
    wr(dbs_pkg::DBG_CFG_ADDR, 1, dbs_pkg::RESP_OKAY);
    cyc(4);
    chk(n_irq - b, 0);
    wr(dbs_pkg::IRQ_SRC_ADDR, 32'h3, dbs_pkg::RESP_OKAY);
    onboard_environment <= 1'b1;
    wr(dbs_pkg::DBG_CFG_ADDR, 1, dbs_pkg::RESP_OKAY);
    u_dbs_far_model.ev(0);
    cyc(4);
    chk(n_irq - b, 1);
    wr(dbs_pkg::IRQ_SRC_ADDR, 32'hfffc, dbs_pkg::RESP_OKAY);
    rd_chk(dbs_pkg::IRQ_SRC_ADDR, 1, dbs_pkg::RESP_OKAY);
    u_dbs_far_model.ev(0);
    cyc(4);
    chk(n_irq - b, 1);
    // Clear and a new receive event land on the same edge
    fork
      wr(dbs_pkg::IRQ_SRC_ADDR, 1, dbs_pkg::RESP_OKAY);
      begin
        do @(posedge clk); while (!(req.awvalid && rsp.awready));
        u_dbs_far_model.ev(0);
      end
    join
    rd_chk(dbs_pkg::IRQ_SRC_ADDR, 1, dbs_pkg::RESP_OKAY);
    wr(dbs_pkg::IRQ_SRC_ADDR, 1, dbs_pkg::RESP_OKAY);
    rd_chk(dbs_pkg::IRQ_SRC_ADDR, 0, dbs_pkg::RESP_OKAY);
    b = n_irq;
    chk(n_rst, 0);
    u_dbs_far_model.ev(2);
    cyc(4);
    chk(n_rst, 1);
    chk(n_irq - b, 0);
    $display("test interrupt done");
  endtask
  task automatic t_abort();
    int bi, ba;
    bi = n_irq;
    ba = n_abt;
    wr(dbs_pkg::ABORT_GEN_ADDR, 32'hfffe, dbs_pkg::RESP_OKAY);
    cyc(4);
    chk(n_abt - ba, 0);
    chk(n_irq - bi, 0);
    rd_chk(dbs_pkg::IRQ_SRC_ADDR, 0, dbs_pkg::RESP_OKAY);
    // Low byte lane not enabled, so the abort bit is not written
    wstrb_v = 4'he;
    wr(dbs_pkg::ABORT_GEN_ADDR, 1, dbs_pkg::RESP_OKAY);
    wstrb_v = 4'hf;
    cyc(4);
    chk(n_abt - ba, 0);
    wr(dbs_pkg::ABORT_GEN_ADDR, 1, dbs_pkg::RESP_OKAY);
    cyc(4);
    chk(n_abt - ba, 1);
    chk(n_irq - bi, 1);
    rd_chk(dbs_pkg::IRQ_SRC_ADDR, 2, dbs_pkg::RESP_OKAY);
    wr(dbs_pkg::IRQ_SRC_ADDR, 2, dbs_pkg::RESP_OKAY);
    u_dbs_far_model.ev(1);
    cyc(4);
    rd_chk(dbs_pkg::IRQ_SRC_ADDR, 2, dbs_pkg::RESP_OKAY);
    chk(n_irq - bi, 2);
    wr(dbs_pkg::IRQ_SRC_ADDR, 3, dbs_pkg::RESP_OKAY);
    $display("test abort done");
  endtask
  task automatic t_pin();
    int n, b;
    n = 0;
    core_rst <= 1'b1;
    cyc(3);
    chk(pin_oe, 1);
    sel_io <= 1'b1;
    cyc(2);
    chk(pin_oe, 0);
    sel_io <= 1'b0;
    core_rst <= 1'b0;
    repeat (6) begin
      @(posedge clk);
      n += (pin_oe === 1'b1);
    end
    chk(n >= 3, 1);
    dev <= 1'b1;
    wr(dbs_pkg::DBG_CFG_ADDR, 32'hff, dbs_pkg::RESP_OKAY);
    rd_chk(dbs_pkg::DBG_CFG_ADDR, 32'h7, dbs_pkg::RESP_OKAY);
    chk(frz, 1);
    zone0_select <= 1'b1;
    b = n_brk;
    // Pin held high by the break hardware: no break
    instr(1);
    chk(n_brk - b, 0);
    u_dbs_far_model.brk(1);
    instr(1);
    chk(n_brk - b, 1);
    instr(0);
    chk(n_brk - b, 1);
    zone0_select <= 1'b0;
    zone1_select <= 1'b1;
    wr(dbs_pkg::DBG_CFG_ADDR, 1, dbs_pkg::RESP_OKAY);
    instr(1);
    chk(n_brk - b, 1);
    u_dbs_far_model.brk(0);
    zone1_select <= 1'b0;
    dev <= 1'b0;
    $display("test pin done");
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {clk, rstn, dev, core_rst, sel_io, zone0_select, zone1_select, fetch, exec, flush, strap} = '0;
    onboard_environment = 1'b1;
    wstrb_v = 4'hf;
    req = '0;
    t_reset(1'b0);
    t_irq();
    t_abort();
    t_pin();
    t_reset(1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
